/* rtl/sfl_cfg.svh */
// constants for the fast-lock and denominator configuration block
// Function
// - mode bit 0: denominator uses only its low 12 bits, upper ten ignored
// - mode bit 1: denominator is upper ten bits joined to low 12 bits
// - fast-lock word: 24 bits, code 1101 low, then count, current, slip fields
// - count 0, 2 and 3 disable fast-lock; pin becomes general-purpose output
// - disabled pin: count 0 high impedance, 2 drives low, 3 drives high
// - count 1 is manual: fast-lock held without limit, pin driven low
// - count 4 to 16383 enables timed fast-lock; pin shows fast-lock
// - timed fast-lock lasts exactly twice the count in comparison cycles
// - during fast-lock pump multiplier is current field plus one
// - slip field: 0 off, 1 half, 2 quarter, 3 sixteenth sample rate
`ifndef SFL_CFG_SVH
`define SFL_CFG_SVH

// ==========================================================================
// serial word layout
`define SFL_WORD_W       24
`define SFL_CODE_MSB     3
`define SFL_CODE_LSB     0
`define SFL_CODE_FLC     4'hD
`define SFL_CODE_DEN     4'hB
`define SFL_TOC_MSB      17
`define SFL_TOC_LSB      4
`define SFL_CPF_MSB      21
`define SFL_CPF_LSB      18
`define SFL_SLIP_MSB     23
`define SFL_SLIP_LSB     22
`define SFL_DENHI_MSB    23
`define SFL_DENHI_LSB    14

// ==========================================================================
// count field codes and reset values
`define SFL_TOC_HIZ      14'h0000
`define SFL_TOC_MANUAL   14'h0001
`define SFL_TOC_LOW      14'h0002
`define SFL_TOC_HIGH     14'h0003
`define SFL_TOC_MIN      14'h0004
`define SFL_CNT_LAST     15'h0001
`define SFL_MULT_ONE     5'h01
`define SFL_DENHI_ZERO   10'h000

`endif

/* rtl/sfl_pkg.sv */
// types shared by the fast-lock configuration block
package sfl_pkg;

   // gray along off -> timed, manual beside it
   typedef enum logic [1:0] {
      SFL_OFF    = 2'h0,
      SFL_TIMED  = 2'h1,
      SFL_MANUAL = 2'h3
   } sfl_state_e;

   typedef struct packed {
      logic [2:0]  sck;
      logic [1:0]  sdi;
      logic [2:0]  le;
      logic [2:0]  pd;
      logic [23:0] shift;
      logic [23:0] ctrl;
      logic [9:0]  den_hi;
      sfl_state_e  state;
      logic [14:0] cnt;
      logic        pin;
      logic        pin_oe;
      logic        active;
      logic [4:0]  mult;
      logic [21:0] den;
      logic [2:0]  slip_shift;
   } sfl_state_s;

endpackage : sfl_pkg

/* rtl/sfl_top.sv */
// fast-lock control word, time-out counter and fractional denominator select
`timescale 1ns/100ps
`include "sfl_cfg.svh"

module sfl_top
   import sfl_pkg::*;
(
   input  wire logic        core_clk_in,
   input  wire logic        rst_n_in,
   input  wire logic        ser_clk_in,
   input  wire logic        ser_data_in,
   input  wire logic        ser_latch_in,
   input  wire logic        pd_clk_in,
   input  wire logic        ext_res_mode_in,
   input  wire logic [11:0] frac_den_low_in,
   input  wire logic [4:0]  steady_pump_mult_in,
   output logic      [21:0] frac_denominator_out,
   output logic             boost_indicator_pin_out,
   output logic             boost_indicator_pin_oe_out,
   output logic             boost_active_out,
   output logic      [4:0]  pump_mult_out,
   output logic      [1:0]  slip_reduction_sel_out,
   output logic      [2:0]  slip_shift_out
);

   // =======================================================================
   // helpers
   function automatic logic [2:0] slip_shift_of(input logic [1:0] sel);
      case (sel)
         2'h0:    slip_shift_of = 3'h0;
         2'h1:    slip_shift_of = 3'h1;
         2'h2:    slip_shift_of = 3'h2;
         default: slip_shift_of = 3'h4;
      endcase
   endfunction : slip_shift_of

   function automatic logic [13:0] toc_of(input logic [23:0] w);
      toc_of = w[`SFL_TOC_MSB:`SFL_TOC_LSB];
   endfunction : toc_of

   function automatic logic [3:0] cpf_of(input logic [23:0] w);
      cpf_of = w[`SFL_CPF_MSB:`SFL_CPF_LSB];
   endfunction : cpf_of

   // =======================================================================
   // state
   sfl_state_s q, d;
   logic       sck_rise;
   logic       le_rise;
   logic       pd_rise;
   logic       flc_load;
   logic [13:0] toc_d;

   assign sck_rise = q.sck[1] & ~q.sck[2];
   assign le_rise  = q.le[1] & ~q.le[2];
   assign pd_rise  = q.pd[1] & ~q.pd[2];
   assign flc_load = le_rise &
                     (q.shift[`SFL_CODE_MSB:`SFL_CODE_LSB] == `SFL_CODE_FLC);

   always_comb begin
      d = q;
      // pins from outside: bit 0 is only read by bit 1
      d.sck = {q.sck[1:0], ser_clk_in};
      d.sdi = {q.sdi[0], ser_data_in};
      d.le  = {q.le[1:0], ser_latch_in};
      d.pd  = {q.pd[1:0], pd_clk_in};

      // msb first; data sampled alongside the clock so both share one latency
      if (sck_rise) begin
         d.shift = {q.shift[22:0], q.sdi[1]};
      end

      if (flc_load) begin
         d.ctrl = q.shift;
      end
      if (le_rise && (q.shift[`SFL_CODE_MSB:`SFL_CODE_LSB] == `SFL_CODE_DEN)) begin
         d.den_hi = q.shift[`SFL_DENHI_MSB:`SFL_DENHI_LSB];
      end

      case (q.state)
         SFL_TIMED: begin
            if (pd_rise) begin
               if (q.cnt == `SFL_CNT_LAST) begin
                  d.state = SFL_OFF;
               end else begin
                  d.cnt = q.cnt - `SFL_CNT_LAST;
               end
            end
         end
         SFL_MANUAL: d.state = SFL_MANUAL;
         SFL_OFF:    d.state = SFL_OFF;
         default:    d.state = SFL_OFF;
      endcase

      // a new word restarts the mode, even mid period
      if (flc_load) begin
         if (toc_of(q.shift) == `SFL_TOC_MANUAL) begin
            d.state = SFL_MANUAL;
         end else if (toc_of(q.shift) >= `SFL_TOC_MIN) begin
            d.state = SFL_TIMED;
            d.cnt   = {toc_of(q.shift), 1'b0};
         end else begin
            d.state = SFL_OFF;
         end
      end

      toc_d = toc_of(d.ctrl);
      case (d.state)
         SFL_TIMED: begin
            d.pin    = 1'b1;
            d.pin_oe = 1'b1;
         end
         SFL_MANUAL: begin
            d.pin    = 1'b0;
            d.pin_oe = 1'b1;
         end
         default: begin
            // expired timed mode keeps driving an inactive indication
            d.pin    = (toc_d == `SFL_TOC_HIGH);
            d.pin_oe = (toc_d != `SFL_TOC_HIZ);
         end
      endcase

      d.active = (d.state != SFL_OFF);
      if (d.active) begin
         d.mult = {1'b0, cpf_of(d.ctrl)} + `SFL_MULT_ONE;
      end else begin
         d.mult = steady_pump_mult_in;
      end

      if (ext_res_mode_in) begin
         d.den = {d.den_hi, frac_den_low_in};
      end else begin
         d.den = {`SFL_DENHI_ZERO, frac_den_low_in};
      end
      d.slip_shift = slip_shift_of(d.ctrl[`SFL_SLIP_MSB:`SFL_SLIP_LSB]);
   end

   always_ff @(posedge core_clk_in) begin
      if (!rst_n_in) begin
         q        <= '0;
         q.state  <= SFL_OFF;
         q.mult   <= `SFL_MULT_ONE;
      end else begin
         q <= d;
      end
   end

   assign frac_denominator_out       = q.den;
   assign boost_indicator_pin_out    = q.pin;
   assign boost_indicator_pin_oe_out = q.pin_oe;
   assign boost_active_out           = q.active;
   assign pump_mult_out              = q.mult;
   assign slip_reduction_sel_out     = q.ctrl[`SFL_SLIP_MSB:`SFL_SLIP_LSB];
   assign slip_shift_out             = q.slip_shift;

   // =======================================================================
   // assertions
   default clocking cb @(posedge core_clk_in); endclocking
   default disable iff (!rst_n_in);

   property p_den_narrow;
      !ext_res_mode_in |=> frac_denominator_out == {`SFL_DENHI_ZERO, $past(frac_den_low_in)};
   endproperty
   a_den_narrow: assert property (p_den_narrow) else $error("narrow denominator wrong");

   property p_den_wide;
      ext_res_mode_in && !le_rise |=>
         frac_denominator_out == {$past(q.den_hi), $past(frac_den_low_in)};
   endproperty
   a_den_wide: assert property (p_den_wide) else $error("wide denominator wrong");

   property p_code_filter;
      le_rise && !flc_load |=> $stable(q.ctrl);
   endproperty
   a_code_filter: assert property (p_code_filter) else $error("foreign word loaded");

   property p_disabled_mode;
      toc_of(q.ctrl) < `SFL_TOC_MIN && toc_of(q.ctrl) != `SFL_TOC_MANUAL |->
         !boost_active_out;
   endproperty
   a_disabled_mode: assert property (p_disabled_mode) else $error("fast-lock not off");

   property p_gpo_pin;
      q.state == SFL_OFF |->
         (boost_indicator_pin_oe_out == (toc_of(q.ctrl) != `SFL_TOC_HIZ)) &&
         (boost_indicator_pin_out == (toc_of(q.ctrl) == `SFL_TOC_HIGH));
   endproperty
   a_gpo_pin: assert property (p_gpo_pin) else $error("pin level wrong");

   property p_manual;
      toc_of(q.ctrl) == `SFL_TOC_MANUAL |->
         boost_active_out && boost_indicator_pin_oe_out && !boost_indicator_pin_out;
   endproperty
   a_manual: assert property (p_manual) else $error("manual mode wrong");

   property p_timed_entry;
      flc_load && toc_of(q.shift) >= `SFL_TOC_MIN |=>
         q.state == SFL_TIMED && boost_indicator_pin_out &&
         q.cnt == {$past(toc_of(q.shift)), 1'b0};
   endproperty
   a_timed_entry: assert property (p_timed_entry) else $error("timed entry wrong");

   sequence s_last_edge;
      q.state == SFL_TIMED && pd_rise && q.cnt == `SFL_CNT_LAST && !flc_load;
   endsequence
   sequence s_idle;
      q.state == SFL_OFF && !boost_active_out && !boost_indicator_pin_out;
   endsequence

   property p_count_step;
      q.state == SFL_TIMED && pd_rise && q.cnt != `SFL_CNT_LAST && !flc_load |=>
         q.cnt == $past(q.cnt) - `SFL_CNT_LAST && q.state == SFL_TIMED;
   endproperty
   a_count_step: assert property (p_count_step) else $error("count step wrong");

   property p_expiry;
      s_last_edge |=> s_idle ##0 (pump_mult_out == $past(steady_pump_mult_in));
   endproperty
   a_expiry: assert property (p_expiry) else $error("expiry wrong");

   property p_mult;
      boost_active_out |-> pump_mult_out == {1'b0, cpf_of(q.ctrl)} + `SFL_MULT_ONE;
   endproperty
   a_mult: assert property (p_mult) else $error("boost multiplier wrong");

   property p_slip;
      slip_shift_out == slip_shift_of(slip_reduction_sel_out);
   endproperty
   a_slip: assert property (p_slip) else $error("slip shift wrong");

endmodule : sfl_top

/* sim/sfl_host_model.sv */
// serial programming host model: shifts 24-bit words msb first, then pulses latch
`timescale 1ns/100ps
module sfl_host_model (
   output logic ser_clk_out,
   output logic ser_data_out,
   output logic ser_latch_out
);
   initial begin
      ser_clk_out   = 1'b0;
      ser_data_out  = 1'b0;
      ser_latch_out = 1'b0;
   end

   // ======================================================================
   // word transfer
   // the 7 ns skew keeps pin edges away from core clock edges
   task automatic send(input logic [23:0] word);
      for (int i = 23; i >= 0; i--) begin
         ser_data_out = word[i];
         #107 ser_clk_out = 1'b1;
         #200 ser_clk_out = 1'b0;
         #93;
      end
      // released data line must not keep showing the last bit
      ser_data_out = ~word[0];
      #107 ser_latch_out = 1'b1;
      #200 ser_latch_out = 1'b0;
      #93;
   endtask : send
endmodule : sfl_host_model

/* sim/test_sfl_top.sv */
// self-checking bench: serial words in, fast-lock pin, pump and denominator out
`timescale 1ns/100ps
module test_sfl_top;
   // ======================================================================
   // stimulus, observed outputs and model state
   logic        clk = 1'b0, rst_n = 1'b0, pd_clk = 1'b0, mode = 1'b0;
   logic [11:0] den_lo = 12'h000;
   logic [4:0]  steady = 5'h01;
   logic [9:0]  den_hi = 10'h000;
   logic [15:0] lfsr = 16'hB7F7;
   wire         sck, sdi, sle;
   logic [21:0] den;
   logic        pin, oe, act;
   logic [4:0]  mult;
   logic [1:0]  slip;
   logic [2:0]  shift;
   int          err_count = 0, compares = 0, cyc = 0, rises = 0, r0 = 0, toc, cpf, slp;

   always #25 clk = ~clk;
   initial #38 forever #200 pd_clk = ~pd_clk;
   always @(posedge pd_clk) rises++;
   always @(posedge sle) r0 = rises;
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         err_count++;
         results();
      end
   end

   sfl_host_model host (.ser_clk_out(sck), .ser_data_out(sdi), .ser_latch_out(sle));
   sfl_top DUT (
      .core_clk_in(clk), .rst_n_in(rst_n), .ser_clk_in(sck), .ser_data_in(sdi),
      .ser_latch_in(sle), .pd_clk_in(pd_clk), .ext_res_mode_in(mode),
      .frac_den_low_in(den_lo), .steady_pump_mult_in(steady),
      .frac_denominator_out(den), .boost_indicator_pin_out(pin),
      .boost_indicator_pin_oe_out(oe), .boost_active_out(act), .pump_mult_out(mult),
      .slip_reduction_sel_out(slip), .slip_shift_out(shift)
   );

   // ======================================================================
   // helpers
   function automatic logic [15:0] rnd();
      lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
      return lfsr;
   endfunction : rnd

   task automatic chk(input string name, input logic [21:0] exp, input logic [21:0] got);
      compares++;
      if (got !== exp) begin
         err_count++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
      end
   endtask : chk

   task automatic results();
      if (err_count == 0 && compares > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : results

   task automatic check_outs();
      logic a;
      a = (toc == 1 || toc >= 4);
      chk("active", 22'(a), 22'(act));
      chk("pin", 22'(toc == 3 || toc >= 4), 22'(pin));
      chk("pin enable", 22'(toc != 0), 22'(oe));
      chk("pump", 22'(a ? cpf + 1 : steady), 22'(mult));
      chk("slip", 22'(slp), 22'(slip));
      chk("slip shift", 22'(slp == 3 ? 4 : slp), 22'(shift));
   endtask : check_outs

   task automatic write_flc(input int t, input int c, input int s);
      toc = t;
      cpf = c;
      slp = s;
      host.send({2'(s), 4'(c), 14'(t), 4'hD});
      @(negedge clk);
      check_outs();
   endtask : write_flc

   // ======================================================================
   // main sequence
   initial begin
      repeat (20) @(negedge clk);
      rst_n = 1'b1;
      chk("reset pump", 22'h000001, 22'(mult));
      chk("reset enable", 22'h000000, 22'(oe));
      for (int m = 0; m < 2; m++) begin
         den_hi = 10'(rnd());
         host.send({den_hi, 10'h155, 4'hB});
         @(negedge clk);
         mode = m[0];
         den_lo = 12'(rnd());
         repeat (2) @(negedge clk);
         chk("denominator", m ? {den_hi, den_lo} : {10'h000, den_lo}, den);
      end
      for (int i = 0; i < 4; i++) begin
         steady = 5'(rnd());
         write_flc(i, rnd() % 16, i);
      end
      // a word with an unknown code must leave everything as it was
      host.send(24'hFFFFF0);
      @(negedge clk);
      check_outs();
      for (int t = 4; t < 6; t++) begin
         write_flc(t, 15, t - 4);
         for (int w = 0; w < 400 && act === 1'b1; w++) @(negedge clk);
         chk("fast-lock length", 22'(2 * t), 22'(rises - r0));
         chk("pin after expiry", 22'h000000, 22'(pin));
         chk("pump after expiry", 22'(steady), 22'(mult));
      end
      results();
   end
endmodule : test_sfl_top
